/* File: common/evc_pkg.sv */
package evc_pkg;

   localparam int EVC_ADDR_W = 64;

   // fixed physical vector offsets, measured from physical zero
   localparam logic [19:0] EVC_VEC_RESET  = 20'h0_0100;
   localparam logic [19:0] EVC_VEC_MCHECK = 20'h0_0200;
   localparam logic [19:0] EVC_VEC_DSTOR  = 20'h0_0300;
   localparam logic [19:0] EVC_VEC_DSEG   = 20'h0_0380;
   localparam logic [19:0] EVC_VEC_ISTOR  = 20'h0_0400;
   localparam logic [19:0] EVC_VEC_EXTINT = 20'h0_0500;
   localparam logic [19:0] EVC_VEC_DECR   = 20'h0_0900;

   // register map, word addresses
   localparam logic [3:0] EVC_REG_CTRL   = 4'h0;
   localparam logic [3:0] EVC_REG_STATUS = 4'h1;
   localparam logic [3:0] EVC_REG_IRQST  = 4'h2;
   localparam logic [3:0] EVC_REG_IRQMSK = 4'h3;
   localparam logic [3:0] EVC_REG_LAST   = 4'h4;
   localparam logic [3:0] EVC_REG_SRRPC  = 4'h5;

   // control register field positions
   localparam int EVC_CTRL_EE_BIT = 0;
   localparam int EVC_CTRL_ME_BIT = 1;
   localparam int EVC_CTRL_DR_BIT = 2;
   localparam int EVC_CTRL_RI_BIT = 3;
   localparam logic [31:0] EVC_CTRL_RST = 32'h0000_0002;

   // status register field positions
   localparam int EVC_ST_CHKSTOP_BIT = 0;
   localparam int EVC_ST_SUPER_BIT   = 1;
   localparam int EVC_ST_RI_BIT      = 2;

   // interrupt status bits
   localparam int EVC_IRQ_TAKEN_BIT = 0;
   localparam int EVC_IRQ_CHKST_BIT = 1;
   localparam int EVC_IRQ_UNREC_BIT = 2;
   localparam int EVC_IRQ_W         = 3;

   typedef enum logic [2:0] {
      EVC_EX_NONE,
      EVC_EX_RESET,
      EVC_EX_MCHECK,
      EVC_EX_DSTOR,
      EVC_EX_DSEG,
      EVC_EX_ISTOR,
      EVC_EX_EXTINT,
      EVC_EX_DECR
   } evc_kind_t;

   // events raised by the pipeline; the external pins come in on their own inputs
   typedef struct packed {
      logic sreset;
      logic sreset_corrupt;
      logic mcheck;
      logic mcheck_corrupt;
      logic dstor;
      logic dseg_miss;
      logic istor;
      logic extint;
      logic decr;
   } evc_event_t;

   // one taken exception
   typedef struct packed {
      evc_kind_t             kind;
      logic                  is_async;
      logic                  is_precise;
      logic [EVC_ADDR_W-1:0] vector;
   } evc_take_t;

endpackage

/* File: hdl/evc_sync3.sv */
`timescale 1ns/1ps
module evc_sync3 (
   // clock and reset
   input  wire logic i_sys_clk,
   input  wire logic i_rst,
   // pin in, filtered level out
   input  wire logic i_async,
   output logic      o_level
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   // a change counts once stages two and three agree
   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         s1_r    <= 1'b0;
         s2_r    <= 1'b0;
         s3_r    <= 1'b0;
         o_level <= 1'b0;
      end else begin
         s1_r <= i_async;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            o_level <= s3_r;
         end
      end
   end
endmodule

/* File: hdl/evc_classifier.sv */
`timescale 1ns/1ps
module evc_classifier
   import evc_pkg::*;
(
   // clock and reset
   input  wire logic                  i_sys_clk,
   input  wire logic                  i_rst,
   // pipeline side
   input  wire evc_event_t            i_event,
   input  wire logic                  i_fp_imprecise,
   input  wire logic [EVC_ADDR_W-1:0] i_cur_pc,
   input  wire logic                  i_resume,
   // external pins
   input  wire logic                  i_mcheck_pin,
   input  wire logic                  i_extint_pin,
   // register port
   input  wire logic [3:0]            i_addr,
   input  wire logic [31:0]           i_wdata,
   input  wire logic                  i_wr,
   input  wire logic                  i_rd,
   output logic [31:0]                o_rdata,
   // exception output
   output evc_take_t                  o_take,
   output logic                       o_take_vld,
   output logic [EVC_ADDR_W-1:0]      o_save_pc,
   output logic [31:0]                o_save_status,
   output logic                       o_supervisor,
   output logic                       o_checkstop,
   output logic                       o_irq
);
   import evc_pkg::*;

   logic mcheck_lvl;
   logic extint_lvl;
   logic mcheck_prev_r;

   evc_sync3 u_sync_mc (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_async   (i_mcheck_pin),
      .o_level   (mcheck_lvl)
   );

   evc_sync3 u_sync_ei (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_async   (i_extint_pin),
      .o_level   (extint_lvl)
   );

   logic [31:0]              ctrl_r;
   logic [EVC_IRQ_W-1:0]     irq_st_r;
   logic [EVC_IRQ_W-1:0]     irq_msk_r;
   logic [2:0]               last_kind_r;
   logic                     sup_r;
   logic                     chk_r;

   wire ee_en = ctrl_r[EVC_CTRL_EE_BIT];
   wire me_en = ctrl_r[EVC_CTRL_ME_BIT];
   wire dr_en = ctrl_r[EVC_CTRL_DR_BIT];
   wire ri_en = ctrl_r[EVC_CTRL_RI_BIT];

   // machine check is a rising edge of pin or a pipeline pulse
   wire mc_edge = (mcheck_lvl & ~mcheck_prev_r) | i_event.mcheck;
   wire ei_pend = extint_lvl | i_event.extint;

   // machine check with enable clear goes to checkstop, never vectors
   wire mc_take = mc_edge & me_en;
   wire mc_stop = mc_edge & ~me_en;
   wire ei_take = ei_pend & ee_en;
   wire dc_take = i_event.decr & ee_en;
   wire ds_take = i_event.dseg_miss & dr_en;

   // fixed priority, highest first; nothing is taken once stopped
   evc_kind_t kind_nxt;
   assign kind_nxt = chk_r              ? EVC_EX_NONE   :
                     i_event.sreset     ? EVC_EX_RESET  :
                     mc_take            ? EVC_EX_MCHECK :
                     i_event.dstor      ? EVC_EX_DSTOR  :
                     ds_take            ? EVC_EX_DSEG   :
                     i_event.istor      ? EVC_EX_ISTOR  :
                     ei_take            ? EVC_EX_EXTINT :
                     dc_take            ? EVC_EX_DECR   :
                                          EVC_EX_NONE;

   logic [19:0] off_nxt;
   logic        async_nxt;
   always_comb begin
      off_nxt   = 20'h0_0000;
      async_nxt = 1'b0;
      case (kind_nxt)
         EVC_EX_RESET: begin
            off_nxt   = EVC_VEC_RESET;
            async_nxt = 1'b1;
         end
         EVC_EX_MCHECK: begin
            off_nxt   = EVC_VEC_MCHECK;
            async_nxt = 1'b1;
         end
         EVC_EX_DSTOR:  off_nxt = EVC_VEC_DSTOR;
         EVC_EX_DSEG:   off_nxt = EVC_VEC_DSEG;
         EVC_EX_ISTOR:  off_nxt = EVC_VEC_ISTOR;
         EVC_EX_EXTINT: begin
            off_nxt   = EVC_VEC_EXTINT;
            async_nxt = 1'b1;
         end
         EVC_EX_DECR: begin
            off_nxt   = EVC_VEC_DECR;
            async_nxt = 1'b1;
         end
         default: begin
            off_nxt   = 20'h0_0000;
            async_nxt = 1'b0;
         end
      endcase
   end

   wire take_nxt = (kind_nxt != EVC_EX_NONE);
   // synchronous exceptions precise unless flagged fp imprecise
   wire precise_nxt = async_nxt | ~i_fp_imprecise;
   // vector zero-extended: physical, no translation applied
   wire [EVC_ADDR_W-1:0] vec_nxt =
      {{(EVC_ADDR_W-20){1'b0}}, off_nxt};

   // recoverable copy cleared when the cause corrupted state
   wire corrupt_nxt =
      ((kind_nxt == EVC_EX_RESET)  & i_event.sreset_corrupt) |
      ((kind_nxt == EVC_EX_MCHECK) & i_event.mcheck_corrupt);
   wire ri_copy = ri_en & ~corrupt_nxt;

   wire [31:0] status_nxt = {28'h000_0000, ri_copy, dr_en, me_en, ee_en};

   // register decode
   wire wr_ctrl = i_wr & (i_addr == EVC_REG_CTRL);
   wire wr_irqs = i_wr & (i_addr == EVC_REG_IRQST);
   wire wr_irqm = i_wr & (i_addr == EVC_REG_IRQMSK);

   wire [EVC_IRQ_W-1:0] irq_ev = {corrupt_nxt, mc_stop & ~chk_r, take_nxt};
   // set wins over a write-one clear
   wire [EVC_IRQ_W-1:0] irq_st_nxt =
      (irq_st_r & ~(wr_irqs ? i_wdata[EVC_IRQ_W-1:0] : 3'h0)) | irq_ev;

   wire [31:0] status_rd = {29'h0000_0000, ri_en, sup_r, chk_r};

   logic [31:0] rdata_nxt;
   always_comb begin
      case (i_addr)
         EVC_REG_CTRL:   rdata_nxt = ctrl_r;
         EVC_REG_STATUS: rdata_nxt = status_rd;
         EVC_REG_IRQST:  rdata_nxt = {29'h0000_0000, irq_st_r};
         EVC_REG_IRQMSK: rdata_nxt = {29'h0000_0000, irq_msk_r};
         EVC_REG_LAST:   rdata_nxt = {29'h0000_0000, last_kind_r};
         EVC_REG_SRRPC:  rdata_nxt = o_save_pc[31:0];
         default:        rdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         mcheck_prev_r <= 1'b0;
         ctrl_r        <= EVC_CTRL_RST;
         irq_st_r      <= 3'h0;
         irq_msk_r     <= 3'h0;
         last_kind_r   <= 3'h0;
         sup_r         <= 1'b1;
         chk_r         <= 1'b0;
         o_rdata       <= 32'h0000_0000;
         o_irq         <= 1'b0;
      end else begin
         mcheck_prev_r <= mcheck_lvl;
         irq_st_r      <= irq_st_nxt;
         o_irq         <= |(irq_st_nxt & irq_msk_r);
         o_rdata       <= i_rd ? rdata_nxt : 32'h0000_0000;
         if (wr_irqm) begin
            irq_msk_r <= i_wdata[EVC_IRQ_W-1:0];
         end
         if (mc_stop) begin
            chk_r <= 1'b1;
         end
         if (take_nxt) begin
            // entry disables interrupts and machine checks, supervisor on
            ctrl_r[EVC_CTRL_EE_BIT] <= 1'b0;
            ctrl_r[EVC_CTRL_ME_BIT] <= 1'b0;
            ctrl_r[EVC_CTRL_DR_BIT] <= 1'b0;
            sup_r       <= 1'b1;
            last_kind_r <= kind_nxt;
         end else if (wr_ctrl) begin
            ctrl_r <= {28'h000_0000, i_wdata[3:0]};
         end else if (i_resume) begin
            sup_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_rst) begin
         o_take        <= '0;
         o_take_vld    <= 1'b0;
         o_save_pc     <= 64'h0000_0000_0000_0000;
         o_save_status <= 32'h0000_0000;
         o_supervisor  <= 1'b1;
         o_checkstop   <= 1'b0;
      end else begin
         o_take_vld   <= take_nxt;
         o_checkstop  <= chk_r | mc_stop;
         o_supervisor <= take_nxt | (sup_r & ~(i_resume & ~wr_ctrl));
         if (take_nxt) begin
            o_take.kind       <= kind_nxt;
            o_take.is_async   <= async_nxt;
            o_take.is_precise <= precise_nxt;
            o_take.vector     <= vec_nxt;
            o_save_pc         <= i_cur_pc;
            o_save_status     <= status_nxt;
         end
      end
   end

   // assertions
   a_reset_vector: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (i_event.sreset && !chk_r) |=> o_take_vld &&
      o_take.vector == 64'h0000_0000_0000_0100 && o_take.is_async)
      else $error("reset vector wrong");
   a_mcheck_stop: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      mc_stop |=> o_checkstop && !(o_take_vld &&
      o_take.kind == EVC_EX_MCHECK))
      else $error("masked machine check not stopped");
   a_mcheck_vec: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (o_take_vld && o_take.kind == EVC_EX_MCHECK) |->
      o_take.vector == 64'h0000_0000_0000_0200 && $past(me_en))
      else $error("machine check vector wrong");
   a_extint_gate: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (o_take_vld && o_take.kind == EVC_EX_EXTINT) |->
      $past(ee_en) && o_take.vector == 64'h0000_0000_0000_0500)
      else $error("external interrupt taken while disabled");
   a_dseg_gate: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (o_take_vld && o_take.kind == EVC_EX_DSEG) |->
      $past(dr_en) && o_take.vector == 64'h0000_0000_0000_0380)
      else $error("data segment without translation");
   a_ri_clear: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (take_nxt && corrupt_nxt) |=> !o_save_status[EVC_CTRL_RI_BIT])
      else $error("recoverable copy not cleared");
   a_sync_precise: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (o_take_vld && !o_take.is_async) |->
      o_take.is_precise == !$past(i_fp_imprecise))
      else $error("precise tag wrong");
   a_take_super: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      take_nxt |=> o_supervisor && o_save_pc == $past(i_cur_pc) ##1 sup_r)
      else $error("state not saved on entry");
   a_istor_vec: assert property (
      @(posedge i_sys_clk) disable iff (i_rst)
      (o_take_vld && o_take.kind == EVC_EX_ISTOR) |->
      o_take.vector == 64'h0000_0000_0000_0400 && !o_take.is_async)
      else $error("instruction fault vector wrong");
endmodule

/* File: tb/evc_pipe_model.sv */
`timescale 1ns/1ps
module evc_pipe_model
   import evc_pkg::*;
(
   // clock
   input  wire logic             i_sys_clk,
   // toward the classifier
   output evc_event_t            o_event,
   output logic                  o_fp_imprecise,
   output logic [EVC_ADDR_W-1:0] o_cur_pc,
   output logic                  o_mcheck_pin,
   output logic                  o_extint_pin
);
   initial begin
      o_event = '0;
      o_fp_imprecise = 1'b0;
      o_cur_pc = 64'h0000_0000_0000_1000;
      o_mcheck_pin = 1'b0;
      o_extint_pin = 1'b0;
   end

   // one-cycle event; pc moves each time so a stale save shows up
   task automatic raise(input logic [8:0] ev, input logic fp);
      @(posedge i_sys_clk);
      o_event        <= evc_event_t'(ev);
      o_fp_imprecise <= fp;
      o_cur_pc       <= o_cur_pc + 64'h0000_0000_0000_0004;
      @(posedge i_sys_clk);
      o_event        <= '0;
      o_fp_imprecise <= 1'b0;
   endtask

   // pins are slow: the classifier syncs them over several cycles
   task automatic set_mcheck(input logic lvl);
      @(posedge i_sys_clk);
      o_mcheck_pin <= lvl;
   endtask

   task automatic set_ext(input logic lvl);
      @(posedge i_sys_clk);
      o_extint_pin <= lvl;
   endtask
endmodule

/* File: tb/evc_classifier_bench.sv */
`timescale 1ns/1ps
module evc_classifier_bench;
   import evc_pkg::*;

   typedef struct packed {
      logic [8:0]  ev;
      logic        fp;
      logic [3:0]  ctrl;
      evc_kind_t   kind;
      logic [19:0] vec;
      logic        as;
      logic [3:0]  sst;
   } evc_row_t;

   logic                  clk, rst, resume, wr, rd, fp, mpin, epin;
   logic                  vld, sup, cs, irq;
   logic [3:0]            addr;
   logic [31:0]           wdata, rdata, sst, d;
   logic [EVC_ADDR_W-1:0] pc, spc;
   evc_event_t            ev;
   evc_take_t             take;
   int                    num_errors = 0;
   int                    compares = 0;

   // event, fp, ctrl, kind, vector, async, saved status low bits
   evc_row_t rows [11] = '{
      '{9'h100, 1'b0, 4'h8, EVC_EX_RESET,  EVC_VEC_RESET,  1'b1, 4'h8},
      '{9'h180, 1'b0, 4'hb, EVC_EX_RESET,  EVC_VEC_RESET,  1'b1, 4'h3},
      '{9'h040, 1'b0, 4'ha, EVC_EX_MCHECK, EVC_VEC_MCHECK, 1'b1, 4'ha},
      '{9'h060, 1'b0, 4'ha, EVC_EX_MCHECK, EVC_VEC_MCHECK, 1'b1, 4'h2},
      '{9'h010, 1'b0, 4'h8, EVC_EX_DSTOR,  EVC_VEC_DSTOR,  1'b0, 4'h8},
      '{9'h010, 1'b1, 4'h8, EVC_EX_DSTOR,  EVC_VEC_DSTOR,  1'b0, 4'h8},
      '{9'h008, 1'b0, 4'hc, EVC_EX_DSEG,   EVC_VEC_DSEG,   1'b0, 4'hc},
      '{9'h004, 1'b0, 4'h0, EVC_EX_ISTOR,  EVC_VEC_ISTOR,  1'b0, 4'h0},
      '{9'h002, 1'b0, 4'h9, EVC_EX_EXTINT, EVC_VEC_EXTINT, 1'b1, 4'h9},
      '{9'h001, 1'b0, 4'h9, EVC_EX_DECR,   EVC_VEC_DECR,   1'b1, 4'h9},
      '{9'h110, 1'b0, 4'h8, EVC_EX_RESET,  EVC_VEC_RESET,  1'b1, 4'h8}
   };

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   evc_pipe_model pipe_u (.i_sys_clk(clk), .o_event(ev),
      .o_fp_imprecise(fp), .o_cur_pc(pc), .o_mcheck_pin(mpin),
      .o_extint_pin(epin));

   evc_classifier dut_u (.i_sys_clk(clk), .i_rst(rst), .i_event(ev),
      .i_fp_imprecise(fp), .i_cur_pc(pc), .i_resume(resume),
      .i_mcheck_pin(mpin), .i_extint_pin(epin), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .o_take(take), .o_take_vld(vld), .o_save_pc(spc),
      .o_save_status(sst), .o_supervisor(sup), .o_checkstop(cs),
      .o_irq(irq));

   task automatic tally_and_finish();
      if (num_errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wreg(input logic [3:0] a, input logic [31:0] v);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= v;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rreg(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      v = rdata;
   endtask

   // bounded wait; a missing take ends the run
   task automatic expect_take(input evc_kind_t k, input logic [19:0] v,
                              input logic as);
      bit got;
      got = 1'b0;
      for (int i = 0; i < 24 && !got; i++) begin
         #1;
         if (vld === 1'b1) got = 1'b1;
         else @(posedge clk);
      end
      if (!got) begin
         chk(64'h0, 64'h1);
         tally_and_finish();
      end
      chk(take.kind, k);
      chk(take.vector, {44'h0, v});
      chk(take.is_async, as);
      chk(sup, 1'b1);
      chk(spc, pc);
   endtask

   task automatic expect_none(input int n);
      for (int i = 0; i < n; i++) begin
         #1;
         chk(vld, 1'b0);
         @(posedge clk);
      end
   endtask

   task automatic leave();
      @(posedge clk);
      resume <= 1'b1;
      @(posedge clk);
      resume <= 1'b0;
      #1;
      chk(sup, 1'b0);
   endtask

   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = '0;
      wdata = '0;
      resume = 1'b0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      chk(sup, 1'b1);
      chk(cs, 1'b0);
      chk(vld, 1'b0);
      chk(irq, 1'b0);
      rreg(EVC_REG_STATUS, d);
      chk(d, 32'h0000_0002);
      rreg(EVC_REG_CTRL, d);
      chk(d, EVC_CTRL_RST);
      wreg(EVC_REG_IRQMSK, 32'h0000_0001);
      foreach (rows[i]) begin
         wreg(EVC_REG_CTRL, {28'h0, rows[i].ctrl});
         pipe_u.raise(rows[i].ev, rows[i].fp);
         expect_take(rows[i].kind, rows[i].vec, rows[i].as);
         if (!rows[i].as) chk(take.is_precise, !rows[i].fp);
         chk(sst, {28'h0, rows[i].sst});
         chk(irq, 1'b1);
         rreg(EVC_REG_LAST, d);
         chk(d, {29'h0, rows[i].kind});
         rreg(EVC_REG_SRRPC, d);
         chk(d, pc[31:0]);
         wreg(EVC_REG_IRQST, 32'h0000_0007);
         @(posedge clk);
         #1;
         chk(irq, 1'b0);
         leave();
      end
      // refused: no translation, interrupts disabled
      wreg(EVC_REG_CTRL, 32'h0000_000a);
      pipe_u.raise(9'h008, 1'b0);
      expect_none(4);
      pipe_u.raise(9'h002, 1'b0);
      expect_none(4);
      pipe_u.raise(9'h001, 1'b0);
      expect_none(4);
      // pins go through the synchroniser
      pipe_u.set_mcheck(1'b1);
      expect_take(EVC_EX_MCHECK, EVC_VEC_MCHECK, 1'b1);
      pipe_u.set_mcheck(1'b0);
      leave();
      wreg(EVC_REG_CTRL, 32'h0000_0001);
      pipe_u.set_ext(1'b1);
      expect_take(EVC_EX_EXTINT, EVC_VEC_EXTINT, 1'b1);
      pipe_u.set_ext(1'b0);
      leave();
      // machine check while disabled stops the core until the next reset
      wreg(EVC_REG_IRQST, 32'h0000_0007);
      wreg(EVC_REG_CTRL, 32'h0000_0000);
      pipe_u.raise(9'h040, 1'b0);
      expect_none(4);
      chk(cs, 1'b1);
      rreg(EVC_REG_STATUS, d);
      chk(d[0], 1'b1);
      pipe_u.raise(9'h010, 1'b0);
      expect_none(4);
      chk(irq, 1'b0);
      wreg(EVC_REG_IRQMSK, 32'h0000_0002);
      @(posedge clk);
      #1;
      chk(irq, 1'b1);
      rreg(4'hf, d);
      chk(d, 32'h0000_0000);
      // second reset in mid-run
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      #1;
      chk(cs, 1'b0);
      chk(sup, 1'b1);
      chk(irq, 1'b0);
      rreg(EVC_REG_CTRL, d);
      chk(d, EVC_CTRL_RST);
      tally_and_finish();
   end
endmodule
